// ### rtl/reset_cause_controller.v
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Five sources all cause system reset
// - Latch pending causes, clear others at entry
// - Several cause flags may be set together
// - Each new reset overwrites recorded causes
// - Status readable anytime, writes ignored
// - Separate flags per source in status
// - Unlock field sequence 01,10,11 opens register
// - Writing 00 relocks, other writes ignored
// - Armed test register forces power-on reset
// - Force bit drives reset-out pin low
// - Software source synchronous, others asynchronous
// - Synchronous reset waits for bus cycle end
// - Bus monitor enabled while waiting
// - Asynchronous sources assert reset at once
// - Hold reset until supply is good
// - Latch watchdog pulse as reset request
// - Software reset held about 2048 cycles
// - Voltage detect resets only when enabled
`include "reset_cause_consts.vh"
module reset_cause_controller #(
    parameter SOFT_HOLD_CYC = `RC_SOFT_HOLD_CYC,
    parameter RELEASE_CYC   = `RC_RELEASE_CYC
) (
    input  wire                  ref_clk_in,
    input  wire                  resetn_in,
    input  wire [`RC_ADDR_W-1:0] addr_in,
    input  wire [7:0]            wdata_in,
    input  wire                  wr_in,
    input  wire                  rd_in,
    output reg  [7:0]            rdata_out,
    input  wire                  power_good_in,
    input  wire                  ext_resetn_in,
    input  wire                  watchdog_timeout_in,
    input  wire                  system_reset_request_bit_in,
    input  wire                  voltage_detect_reset_enable_in,
    input  wire                  voltage_detect_in,
    input  wire                  bus_cycle_active_in,
    output reg                   bus_monitor_en_out,
    output reg                   sys_reset_out,
    output reg                   por_reset_out,
    output reg                   reset_out_pin_n_out,
    output reg                   irq_out
);

// ****************************************************************
// State encoding
// ****************************************************************
localparam ST_RUN  = 4'b0001;
localparam ST_WAIT = 4'b0010;
localparam ST_HOLD = 4'b0100;
localparam ST_REL  = 4'b1000;

localparam CNT_W = 12;

reg  [3:0]            state_q;
reg  [3:0]            state_d;
reg  [CNT_W-1:0]      cnt_q;
reg  [CNT_W-1:0]      cnt_d;
reg  [`RC_ST_W-1:0]   status_q;
reg  [`RC_ST_W-1:0]   irq_stat_q;
reg  [`RC_ST_W-1:0]   irq_mask_q;
reg  [1:0]            key_q;
reg                   armed_q;
reg                   force_por_q;
reg                   force_out_q;
reg                   wdog_latch_q;
reg                   soft_pend_q;
reg                   por_seen_q;

wire                  ext_req;
wire                  vdet_req;
wire                  por_req;
wire                  async_req;
wire [`RC_ST_W-1:0]   pending;
wire                  entry_async;
wire                  entry_sync;
wire                  entry;
wire                  wr_test;
wire                  wr_ctrl;
wire                  wr_irq_stat;
wire                  wr_irq_mask;
wire [1:0]            key_wr;

function [CNT_W-1:0] to_cnt;
    input integer n;
    begin
        to_cnt = n[CNT_W-1:0];
    end
endfunction

// Unlock field: 01, 10, 11 opens; 00 relocks an open field
function [1:0] key_next;
    input [1:0] cur;
    input [1:0] val;
    begin
        case (cur)
            `RC_KEY_OPEN: begin
                key_next = (val == `RC_KEY_LOCK) ? `RC_KEY_LOCK : `RC_KEY_OPEN;
            end
            `RC_KEY_LOCK: begin
                key_next = (val == `RC_KEY_STEP1) ? `RC_KEY_STEP1 : `RC_KEY_LOCK;
            end
            `RC_KEY_STEP1: begin
                key_next = (val == `RC_KEY_STEP2) ? `RC_KEY_STEP2 : `RC_KEY_LOCK;
            end
            default: begin
                key_next = (val == `RC_KEY_OPEN) ? `RC_KEY_OPEN : `RC_KEY_LOCK;
            end
        endcase
    end
endfunction

// ****************************************************************
// Source qualification
// ****************************************************************
assign ext_req   = ~ext_resetn_in;
assign vdet_req  = voltage_detect_reset_enable_in & voltage_detect_in;
assign por_req   = ~power_good_in | force_por_q;
assign async_req = por_req | ext_req | vdet_req | wdog_latch_q | watchdog_timeout_in;

assign pending[`RC_ST_EXT]  = ext_req;
assign pending[`RC_ST_VDET] = vdet_req;
assign pending[`RC_ST_SOFT] = soft_pend_q & ~bus_cycle_active_in;
assign pending[`RC_ST_WDOG] = wdog_latch_q | watchdog_timeout_in;
assign pending[`RC_ST_POR]  = por_req;

assign entry_async = async_req & ~sys_reset_out;
assign entry_sync  = (state_q == ST_WAIT) & ~bus_cycle_active_in;
assign entry       = entry_async | entry_sync;

// ****************************************************************
// Register write decode
// ****************************************************************
assign wr_test     = wr_in & (addr_in == `RC_OFS_TEST_UNLOCK);
assign wr_ctrl     = wr_in & (addr_in == `RC_OFS_OUT_CTRL);
assign wr_irq_stat = wr_in & (addr_in == `RC_OFS_IRQ_STATUS);
assign wr_irq_mask = wr_in & (addr_in == `RC_OFS_IRQ_MASK);
assign key_wr      = wdata_in[`RC_TEST_KEY_HI:`RC_TEST_KEY_LO];

// ****************************************************************
// Sequencer
// ****************************************************************
always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
        ST_RUN: begin
            if (async_req) begin
                state_d = ST_HOLD;
            end else if (system_reset_request_bit_in) begin
                state_d = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (async_req) begin
                state_d = ST_HOLD;
            end else if (~bus_cycle_active_in) begin
                state_d = ST_HOLD;
                cnt_d   = to_cnt(SOFT_HOLD_CYC - 1);
            end
        end
        ST_HOLD: begin
            if (async_req) begin
                cnt_d = to_cnt(0);
            end else if (cnt_q != to_cnt(0)) begin
                cnt_d = cnt_q - to_cnt(1);
            end else begin
                state_d = ST_REL;
                cnt_d   = to_cnt(RELEASE_CYC - 1);
            end
        end
        ST_REL: begin
            if (async_req) begin
                state_d = ST_HOLD;
                cnt_d   = to_cnt(0);
            end else if (cnt_q != to_cnt(0)) begin
                cnt_d = cnt_q - to_cnt(1);
            end else begin
                state_d = ST_RUN;
            end
        end
        default: begin
            state_d = ST_HOLD;
            cnt_d   = to_cnt(0);
        end
    endcase
end

always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        state_q            <= ST_HOLD;
        cnt_q              <= {CNT_W{1'b0}};
        sys_reset_out      <= 1'b1;
        bus_monitor_en_out <= 1'b0;
    end else begin
        state_q <= state_d;
        cnt_q   <= cnt_d;
        // Asynchronous causes assert in the same edge, release only on the step from REL into RUN
        sys_reset_out      <= (state_d != ST_RUN) & (state_d != ST_WAIT);
        bus_monitor_en_out <= (state_d == ST_WAIT);
    end
end

// ****************************************************************
// Request latches
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        wdog_latch_q <= 1'b0;
        soft_pend_q  <= 1'b0;
    end else begin
        // A one-cycle timeout pulse must survive until reset is entered
        if (watchdog_timeout_in) begin
            wdog_latch_q <= 1'b1;
        end else if (state_q == ST_HOLD) begin
            wdog_latch_q <= 1'b0;
        end
        // Requests made while reset is asserted are dropped
        if (state_q == ST_RUN & system_reset_request_bit_in) begin
            soft_pend_q <= 1'b1;
        end else if (state_q == ST_HOLD) begin
            soft_pend_q <= 1'b0;
        end
    end
end

// ****************************************************************
// Power-on class reset
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        por_reset_out <= 1'b1;
        por_seen_q    <= 1'b0;
    end else begin
        por_reset_out <= por_req | (por_seen_q & (state_d != ST_RUN));
        if (por_req) begin
            por_seen_q <= 1'b1;
        end else if (state_d == ST_RUN) begin
            por_seen_q <= 1'b0;
        end
    end
end

// ****************************************************************
// Cause capture
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        status_q <= `RC_STATUS_POR;
    end else if (entry) begin
        status_q <= pending;
    end
end

// ****************************************************************
// Interrupt status and mask
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        irq_stat_q <= {`RC_ST_W{1'b0}};
        irq_mask_q <= {`RC_ST_W{1'b0}};
        irq_out    <= 1'b0;
    end else begin
        // A cause arriving with a clear of the same bit stays set
        if (entry) begin
            irq_stat_q <= (irq_stat_q & ~(wr_irq_stat ? wdata_in[`RC_ST_W-1:0] : {`RC_ST_W{1'b0}})) | pending;
        end else if (wr_irq_stat) begin
            irq_stat_q <= irq_stat_q & ~wdata_in[`RC_ST_W-1:0];
        end
        if (wr_irq_mask) begin
            irq_mask_q <= wdata_in[`RC_ST_W-1:0];
        end
        irq_out <= |(irq_stat_q & irq_mask_q);
    end
end

// ****************************************************************
// Test unlock and forced power-on
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        key_q       <= `RC_KEY_LOCK;
        armed_q     <= 1'b0;
        force_por_q <= 1'b0;
    end else begin
        if (wr_test) begin
            key_q   <= key_next(key_q, key_wr);
            armed_q <= (wdata_in == `RC_TEST_ARM_VALUE);
            // The arming write itself never fires the reset
            if (key_q == `RC_KEY_OPEN & armed_q & wdata_in[`RC_TEST_FORCE_POR]) begin
                force_por_q <= 1'b1;
            end
        end else if (force_por_q & sys_reset_out) begin
            force_por_q <= 1'b0;
        end
    end
end

// ****************************************************************
// Reset-out pin
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        force_out_q         <= 1'b0;
        reset_out_pin_n_out <= 1'b1;
    end else begin
        if (wr_ctrl) begin
            force_out_q <= wdata_in[`RC_CTRL_FORCE_OUT];
        end
        // Pin follows the write in the same edge as the control bit
        reset_out_pin_n_out <= ~(wr_ctrl ? wdata_in[`RC_CTRL_FORCE_OUT] : force_out_q);
    end
end

// ****************************************************************
// Read port
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
        rdata_out <= `RC_BYTE_ZERO;
    end else if (rd_in) begin
        case (addr_in)
            `RC_OFS_TEST_UNLOCK: rdata_out <= {force_por_q, 5'h00, key_q};
            `RC_OFS_STATUS:      rdata_out <= {3'h0, status_q};
            `RC_OFS_OUT_CTRL:    rdata_out <= {7'h00, force_out_q};
            `RC_OFS_IRQ_STATUS:  rdata_out <= {3'h0, irq_stat_q};
            `RC_OFS_IRQ_MASK:    rdata_out <= {3'h0, irq_mask_q};
            default:             rdata_out <= `RC_BYTE_ZERO;
        endcase
    end else begin
        rdata_out <= `RC_BYTE_ZERO;
    end
end

endmodule

// ### rtl/reset_cause_consts.vh
`ifndef RESET_CAUSE_CONSTS_VH
`define RESET_CAUSE_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RC_ADDR_W          4
`define RC_OFS_RESERVED    4'h0
`define RC_OFS_TEST_UNLOCK 4'h1
`define RC_OFS_STATUS      4'h2
`define RC_OFS_OUT_CTRL    4'h3
`define RC_OFS_IRQ_STATUS  4'h4
`define RC_OFS_IRQ_MASK    4'h5

// ****************************************************************
// Field layouts
// ****************************************************************
`define RC_TEST_KEY_LO     0
`define RC_TEST_KEY_HI     1
`define RC_TEST_FORCE_POR  7
`define RC_TEST_ARM_VALUE  8'h5B
`define RC_KEY_STEP1       2'h1
`define RC_KEY_STEP2       2'h2
`define RC_KEY_OPEN        2'h3
`define RC_KEY_LOCK        2'h0

`define RC_ST_EXT          0
`define RC_ST_VDET         1
`define RC_ST_SOFT         2
`define RC_ST_WDOG         3
`define RC_ST_POR          4
`define RC_ST_W            5

`define RC_CTRL_FORCE_OUT  0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RC_BYTE_ZERO       8'h00
`define RC_STATUS_POR      5'h10
`define RC_SOFT_HOLD_CYC   2048
`define RC_RELEASE_CYC     4

`endif

// ### dv/reset_cause_monitor.sv
`timescale 1ns/1ps
`include "reset_cause_consts.vh"
module reset_cause_monitor #(
    parameter SOFT_HOLD_CYC = 8,
    parameter RELEASE_CYC   = 2
) (
    input wire       ref_clk_in,
    input wire       resetn_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in,
    input wire       wr_in,
    input wire       rd_in,
    input wire [7:0] rdata_out,
    input wire       power_good_in,
    input wire       ext_resetn_in,
    input wire       watchdog_timeout_in,
    input wire       system_reset_request_bit_in,
    input wire       voltage_detect_reset_enable_in,
    input wire       voltage_detect_in,
    input wire       bus_cycle_active_in,
    input wire       bus_monitor_en_out,
    input wire       sys_reset_out,
    input wire       por_reset_out,
    input wire       reset_out_pin_n_out
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    wire async_req = !power_good_in || !ext_resetn_in || watchdog_timeout_in ||
                     (voltage_detect_reset_enable_in && voltage_detect_in);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence soft_seen;
        system_reset_request_bit_in && !sys_reset_out && !bus_monitor_en_out && !async_req;
    endsequence
    sequence bus_done;
        bus_monitor_en_out && !bus_cycle_active_in;
    endsequence
    // Hold count of 8 matches the bench's SOFT_HOLD_CYC
    read_stand_a: assert property (rd_in ##1 !rd_in |=> rdata_out == 8'h00)
        else $error("read data stood too long");
    async_now_a: assert property (async_req |=> sys_reset_out)
        else $error("async source did not reset at once");
    por_hold_a: assert property (!power_good_in |=> por_reset_out && sys_reset_out)
        else $error("low supply without power-on reset");
    release_sync_a: assert property ($fell(sys_reset_out) |-> !$past(async_req) && !$past(async_req, 2))
        else $error("reset released too soon after source");
    out_pin_a: assert property (wr_in && addr_in == `RC_OFS_OUT_CTRL |=>
        reset_out_pin_n_out == !$past(wdata_in[0]))
        else $error("reset-out pin level wrong");
    soft_wait_a: assert property (soft_seen |=> bus_monitor_en_out)
        else $error("bus monitor not enabled");
    soft_go_a: assert property (bus_done |=> sys_reset_out)
        else $error("reset not asserted after bus cycle end");
    soft_stall_a: assert property (bus_monitor_en_out && bus_cycle_active_in && !async_req |=> !sys_reset_out)
        else $error("reset asserted during bus cycle");
    soft_len_a: assert property ($rose(sys_reset_out) && $past(bus_monitor_en_out) |-> sys_reset_out[*8])
        else $error("software reset too short");
    wdog_latch_a: assert property (watchdog_timeout_in ##1 !watchdog_timeout_in |-> sys_reset_out[*2])
        else $error("watchdog pulse not latched");
endmodule

// ### dv/reset_source_model.sv
`timescale 1ns/1ps
module reset_source_model (
    input  wire ref_clk_in,
    output reg  watchdog_timeout_out = 1'b0,
    output wire bus_cycle_active_out
);
    // ****************************************************************
    // Watchdog and bus master
    // ****************************************************************
    reg [15:0] cyc_q = 16'h0000;
    reg [15:0] busy_until_q = 16'h0000;
    assign bus_cycle_active_out = (cyc_q < busy_until_q);
    always @(posedge ref_clk_in) begin
        cyc_q <= cyc_q + 16'h0001;
    end
    // Timeout is a single-cycle pulse; the controller takes it directly and also latches it
    task wdog_pulse;
        begin
            watchdog_timeout_out <= 1'b1;
            @(posedge ref_clk_in);
            #1;
            watchdog_timeout_out <= 1'b0;
        end
    endtask
    task bus_hold(input [7:0] n);
        busy_until_q <= cyc_q + {8'h00, n};
    endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "reset_cause_consts.vh"
module testbench;
    reg        ref_clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, sreq = 0, vde = 0, vdi = 0;
    reg        power_good_in = 1, ext_resetn_in = 1;
    reg  [3:0] addr_in = 0;
    reg  [7:0] wdata_in = 0;
    wire [7:0] rdata_out;
    wire       wdog, bus_act, mon, sys_rst, por_rst, pin_n, irq;
    integer    failures = 0, check_count = 0, i, n;
    always #25 ref_clk_in = ~ref_clk_in;
    reset_source_model src_u (.ref_clk_in(ref_clk_in), .watchdog_timeout_out(wdog), .bus_cycle_active_out(bus_act));
    reset_cause_controller #(.SOFT_HOLD_CYC(8), .RELEASE_CYC(2)) dut_u (.ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .power_good_in(power_good_in), .ext_resetn_in(ext_resetn_in),
        .watchdog_timeout_in(wdog), .system_reset_request_bit_in(sreq), .voltage_detect_reset_enable_in(vde),
        .voltage_detect_in(vdi), .bus_cycle_active_in(bus_act), .bus_monitor_en_out(mon),
        .sys_reset_out(sys_rst), .por_reset_out(por_rst), .reset_out_pin_n_out(pin_n), .irq_out(irq));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task end_sim;
        begin
            $display("checks %0d failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick;
        begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'b1;
            tick;
            wr_in <= 1'b0;
            tick;
        end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
        begin
            addr_in <= a;
            rd_in <= 1'b1;
            tick;
            rd_in <= 1'b0;
            chk(rdata_out, exp);
            tick;
        end
    endtask
    task wait_run;
        begin
            for (i = 0; i < 60 && sys_rst !== 1'b0; i = i + 1) tick;
            chk({7'h0, sys_rst}, 8'h00);
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_soft;
        begin
            src_u.bus_hold(8'h06);
            sreq <= 1'b1;
            tick;
            sreq <= 1'b0;
            chk({6'h0, mon, sys_rst}, 8'h02);
            tick;
            tick;
            chk({7'h0, sys_rst}, 8'h00);
            for (i = 0; i < 20 && sys_rst !== 1'b1; i = i + 1) tick;
            for (n = 0; n < 100 && sys_rst === 1'b1; n = n + 1) tick;
            chk({7'h0, n >= 8 && n <= 12}, 8'h01);
            rd(`RC_OFS_STATUS, 8'h04);
            wr(`RC_OFS_IRQ_MASK, 8'h04);
            chk({7'h0, irq}, 8'h01);
            wr(`RC_OFS_IRQ_MASK, 8'h00);
            chk({7'h0, irq}, 8'h00);
            wr(`RC_OFS_IRQ_MASK, 8'h04);
            wr(`RC_OFS_IRQ_STATUS, 8'h1F);
            chk({7'h0, irq}, 8'h00);
        end
    endtask
    task t_async(input integer k, input [7:0] exp);
        begin
            if (k == 0 || k == 4) ext_resetn_in <= 1'b0;
            vde <= (k == 2);
            vdi <= (k == 2 || k == 5);
            if (k == 3) power_good_in <= 1'b0;
            if (k == 1 || k == 4) src_u.wdog_pulse;
            else tick;
            chk({6'h0, por_rst, sys_rst}, exp == 8'h10 ? 8'h03 : {7'h0, k != 5});
            ext_resetn_in <= 1'b1;
            {vde, vdi} <= 2'b00;
            power_good_in <= 1'b1;
            wait_run;
            if (k != 5) rd(`RC_OFS_STATUS, exp);
        end
    endtask
    task t_unlock;
        begin
            wr(1, 8'h01);
            wr(1, 8'h02);
            wr(1, 8'h03);
            rd(1, 8'h03);
            wr(1, 8'h01);
            rd(1, 8'h03);
            wr(1, 8'h00);
            rd(1, 8'h00);
            wr(1, 8'h01);
            wr(1, 8'h03);
            rd(1, 8'h00);
            wr(1, 8'h01);
            wr(1, 8'h02);
            wr(1, `RC_TEST_ARM_VALUE);
            addr_in <= 4'h1;
            wdata_in <= 8'h83;
            wr_in <= 1'b1;
            tick;
            wr_in <= 1'b0;
            for (i = 0; i < 4 && por_rst !== 1'b1; i = i + 1) tick;
            chk({7'h0, por_rst}, 8'h01);
            wait_run;
            rd(`RC_OFS_STATUS, 8'h10);
        end
    endtask
    initial begin
        repeat (6) tick;
        resetn_in <= 1'b1;
        wait_run;
        rd(`RC_OFS_STATUS, 8'h10);
        wr(`RC_OFS_STATUS, 8'hFF);
        rd(`RC_OFS_STATUS, 8'h10);
        rd(`RC_OFS_RESERVED, 8'h00);
        rd(4'h9, 8'h00);
        t_soft;
        t_async(0, 8'h01);
        t_async(1, 8'h08);
        t_async(2, 8'h02);
        t_async(3, 8'h10);
        t_async(4, 8'h09);
        t_async(5, 8'h00);
        t_unlock;
        wr(`RC_OFS_OUT_CTRL, 8'h01);
        chk({7'h0, pin_n}, 8'h00);
        rd(`RC_OFS_OUT_CTRL, 8'h01);
        wr(`RC_OFS_OUT_CTRL, 8'h00);
        chk({7'h0, pin_n}, 8'h01);
        end_sim;
    end
    initial begin
        #200000;
        failures = failures + 1;
        end_sim;
    end
endmodule
bind reset_cause_controller reset_cause_monitor #(.SOFT_HOLD_CYC(SOFT_HOLD_CYC), .RELEASE_CYC(RELEASE_CYC)) mon_u (
    .ref_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .power_good_in, .ext_resetn_in,
    .watchdog_timeout_in, .system_reset_request_bit_in, .voltage_detect_reset_enable_in, .voltage_detect_in,
    .bus_cycle_active_in, .bus_monitor_en_out, .sys_reset_out, .por_reset_out, .reset_out_pin_n_out);
